// *** src/lsad_top.sv ***
// legacy segment attribute decoder: registers, cpu routing, pci claim
`timescale 1ns/1ps
module lsad_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cpu_req_i,
    input  wire logic [31:0] cpu_addr_i,
    input  wire logic        cpu_write_i,
    input  wire logic        cpu_code_i,
    output logic             cpu_valid_o,
    output logic             cpu_to_mem_o,
    output logic             cpu_to_pci_o,
    output logic             cpu_l1_cache_o,
    input  wire logic        pci_req_i,
    input  wire logic [31:0] pci_addr_i,
    input  wire logic        pci_write_i,
    output logic             pci_valid_o,
    output logic             pci_claim_o
);
    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0]  attr_regs [lsad_pkg::NUM_ATTR_REGS];
    logic [7:0]  top_mem;
    logic [31:0] hole_ctrl;
    logic [7:0]  bus_idx;
    logic [2:0]  attr_sel;
    logic        attr_hit;
    logic        bus_req;
    logic        bus_write;
    logic [31:0] next_rdata;

    assign bus_idx   = wb_adr_i[9:2];
    assign bus_req   = wb_cyc_i & wb_stb_i;
    assign attr_sel  = 3'(bus_idx - lsad_pkg::SYSFW_ATTR_IDX);
    assign attr_hit  = (bus_idx >= lsad_pkg::SYSFW_ATTR_IDX)
                     & (bus_idx <= lsad_pkg::FW_EXT_E8_EF_IDX);
    // a write lands at the edge where the master sees ack
    assign bus_write = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];

    // ************************************************************
    // wishbone answer: one wait state, unmapped reads return zero
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= next_rdata;
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        if (attr_hit) begin
            next_rdata = {24'h000000, attr_regs[attr_sel]};
        end else if (bus_idx == lsad_pkg::STATUS_IDX) begin
            next_rdata = {27'h0000000, pci_claim_o, pci_valid_o,
                          cpu_l1_cache_o, cpu_to_pci_o, cpu_to_mem_o};
        end else if (bus_idx == lsad_pkg::TOP_MEM_IDX) begin
            next_rdata = {24'h000000, top_mem};
        end else if (bus_idx == lsad_pkg::HOLE_IDX) begin
            next_rdata = hole_ctrl;
        end
    end

    // ************************************************************
    // attribute registers
    // ************************************************************
    // reserved bits never store, so they always read back zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < lsad_pkg::NUM_ATTR_REGS; i++) begin
                attr_regs[i] <= lsad_pkg::ATTR_RESET;
            end
        end else if (bus_write & attr_hit) begin
            if (attr_sel == 3'h0) begin
                attr_regs[attr_sel] <= wb_dat_i[7:0] & lsad_pkg::SYSFW_WMASK;
            end else begin
                attr_regs[attr_sel] <= wb_dat_i[7:0] & lsad_pkg::ATTR_WMASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            top_mem   <= lsad_pkg::TOP_MEM_RESET;
            hole_ctrl <= lsad_pkg::HOLE_RESET;
        end else if (bus_write & (bus_idx == lsad_pkg::TOP_MEM_IDX)) begin
            top_mem   <= wb_dat_i[7:0];
        end else if (bus_write & (bus_idx == lsad_pkg::HOLE_IDX)) begin
            hole_ctrl <= wb_dat_i & lsad_pkg::HOLE_WMASK;
        end
    end

    // ************************************************************
    // segment fields: two per register, firmware in the top nibble
    // ************************************************************
    lsad_attr_if attr_bus ();

    genvar g;
    generate
        for (g = 0; g < lsad_pkg::NUM_SEGS - 1; g++) begin : g_seg
            // low nibble is the lower segment of each pair
            assign attr_bus.seg_attr[g] =
                attr_regs[g / 2 + 1][(g % 2) * lsad_pkg::NIBBLE_W +: 4];
        end
    endgenerate
    assign attr_bus.seg_attr[lsad_pkg::SYSFW_SEG] = attr_regs[0][7:4];

    // ************************************************************
    // cpu cycle routing
    // ************************************************************
    lsad_pkg::lsad_region_t cpu_region;
    logic [3:0]             cpu_field;
    logic                   next_cpu_mem;
    logic                   next_cpu_pci;
    logic                   next_cpu_l1;

    // lookup is combinational on live registers, so a new field governs
    // the very next cycle; the cost is one more level before the flops
    lsad_seg_lookup u_cpu_lookup (
        .addr_i   (cpu_addr_i),
        .attr     (attr_bus),
        .region_o (cpu_region),
        .field_o  (cpu_field)
    );

    // each segment maps only onto its own dram, so disabled ones fall through to pci
    lsad_route_decode u_cpu_route (
        .region_i (cpu_region),
        .field_i  (cpu_field),
        .write_i  (cpu_write_i),
        .code_i   (cpu_code_i),
        .to_mem_o (next_cpu_mem),
        .to_pci_o (next_cpu_pci),
        .l1_o     (next_cpu_l1)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_valid_o    <= 1'b0;
            cpu_to_mem_o   <= 1'b0;
            cpu_to_pci_o   <= 1'b0;
            cpu_l1_cache_o <= 1'b0;
        end else begin
            cpu_valid_o <= cpu_req_i;
            if (cpu_req_i) begin
                cpu_to_mem_o   <= next_cpu_mem;
                cpu_to_pci_o   <= next_cpu_pci;
                cpu_l1_cache_o <= next_cpu_l1;
            end
        end
    end

    // ************************************************************
    // pci master claim
    // ************************************************************
    lsad_pkg::lsad_region_t pci_region;
    logic [3:0]             pci_field;
    logic                   pci_in_hole;
    logic                   next_pci_claim;

    lsad_seg_lookup u_pci_lookup (
        .addr_i   (pci_addr_i),
        .attr     (attr_bus),
        .region_o (pci_region),
        .field_o  (pci_field)
    );

    // hole is applied last so it overrides every region, low memory too
    assign pci_in_hole = hole_ctrl[lsad_pkg::HOLE_EN_BIT]
        & (pci_addr_i[31:20] >= {4'h0, hole_ctrl[lsad_pkg::HOLE_START_LSB+:8]})
        & (pci_addr_i[31:20] <  {4'h0, hole_ctrl[lsad_pkg::HOLE_END_LSB+:8]});

    always_comb begin
        next_pci_claim = 1'b0;
        case (pci_region)
            lsad_pkg::LSAD_REG_LOW: begin
                next_pci_claim = 1'b1;
            end
            lsad_pkg::LSAD_REG_VIDEO: begin
                next_pci_claim = 1'b0;
            end
            lsad_pkg::LSAD_REG_ATTR: begin
                next_pci_claim = pci_write_i ? pci_field[lsad_pkg::WE_BIT]
                                             : pci_field[lsad_pkg::RE_BIT];
            end
            default: begin
                next_pci_claim = pci_addr_i[31:20] < {4'h0, top_mem};
            end
        endcase
        if (pci_in_hole) begin
            next_pci_claim = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pci_valid_o <= 1'b0;
            pci_claim_o <= 1'b0;
        end else begin
            pci_valid_o <= pci_req_i;
            pci_claim_o <= pci_req_i & next_pci_claim;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic cpu_attr_seg;
    logic pci_attr_seg;
    assign cpu_attr_seg = cpu_req_i & (cpu_region == lsad_pkg::LSAD_REG_ATTR);
    assign pci_attr_seg = pci_req_i & (pci_region == lsad_pkg::LSAD_REG_ATTR);

    AST_LOW_AREA_MEM: assert property (
        cpu_req_i & (cpu_addr_i < 32'h000A0000)
        |=> cpu_valid_o & cpu_to_mem_o & ~cpu_to_pci_o & cpu_l1_cache_o)
        else $error("low area not routed to cacheable memory");

    AST_VIDEO_TO_PCI: assert property (
        cpu_req_i & (cpu_addr_i >= 32'h000A0000) & (cpu_addr_i < 32'h000C0000)
        |=> cpu_to_pci_o & ~cpu_to_mem_o & ~cpu_l1_cache_o)
        else $error("video area not forwarded uncached to pci");

    AST_DISABLED_TO_PCI: assert property (
        cpu_attr_seg & (cpu_field[1:0] == 2'b00)
        |=> cpu_to_pci_o & ~cpu_to_mem_o & ~cpu_l1_cache_o)
        else $error("disabled segment reached memory");

    AST_RO_WRITE_PCI: assert property (
        cpu_attr_seg & cpu_write_i & cpu_field[0] & ~cpu_field[1]
        |=> cpu_to_pci_o & ~cpu_to_mem_o)
        else $error("write to read-only segment stored in memory");

    AST_WO_SPLIT: assert property (
        cpu_attr_seg & (cpu_field[1:0] == 2'b10)
        |=> (cpu_to_mem_o == $past(cpu_write_i)) & (cpu_to_pci_o != cpu_to_mem_o))
        else $error("write-only segment routed wrongly");

    AST_RO_CACHE_CODE: assert property (
        cpu_attr_seg & (cpu_field[1:0] == 2'b01)
        |=> cpu_l1_cache_o == ($past(cpu_field[2]) & $past(cpu_code_i)
                              & ~$past(cpu_write_i)))
        else $error("read-only cacheability wrong");

    AST_RW_CACHE: assert property (
        cpu_attr_seg & ~cpu_write_i & (cpu_field[1:0] == 2'b11)
        |=> cpu_to_mem_o & (cpu_l1_cache_o == $past(cpu_field[2])))
        else $error("read/write segment cacheability wrong");

    AST_PCI_WRITE_CLAIM: assert property (
        pci_attr_seg & pci_write_i & ~pci_in_hole
        |=> pci_valid_o & (pci_claim_o == $past(pci_field[1])))
        else $error("pci write claim disagrees with write enable");

    AST_PCI_READ_CLAIM: assert property (
        pci_attr_seg & ~pci_write_i & ~pci_in_hole
        |=> pci_claim_o == $past(pci_field[0]))
        else $error("pci read claim disagrees with read enable");

    AST_HOLE_NO_CLAIM: assert property (
        pci_req_i & pci_in_hole |=> pci_valid_o ##0 ~pci_claim_o)
        else $error("pci access in hole claimed");

    AST_FW_LOW_RSVD: assert property (
        bus_write & attr_hit & (attr_sel == 3'h0) |=> attr_regs[0][3:0] == 4'h0)
        else $error("firmware reserved nibble stored bits");

    AST_LIVE_FIELD: assert property (
        bus_write & attr_hit & (attr_sel == 3'h1) & (wb_dat_i[1:0] == 2'b00)
        ##1 cpu_req_i & (cpu_addr_i[31:14] == 18'h00030)
        |=> cpu_to_pci_o)
        else $error("new attribute did not govern next cycle");

    AST_LOW_PCI_CLAIM: assert property (
        pci_req_i & (pci_addr_i < 32'h000A0000) & ~pci_in_hole
        |=> pci_valid_o & pci_claim_o)
        else $error("pci access below video area not claimed");

    AST_CLAIM_WITH_VALID: assert property (
        pci_claim_o |-> pci_valid_o)
        else $error("pci claim without a decoded access");

    AST_RE_READ_MEM: assert property (
        cpu_attr_seg & ~cpu_write_i & cpu_field[0]
        |=> cpu_to_mem_o & ~cpu_to_pci_o)
        else $error("readable segment read not sent to memory");

    AST_RSVD_ZERO: assert property (
        (((attr_regs[1] | attr_regs[2] | attr_regs[3] | attr_regs[4] | attr_regs[5]
           | attr_regs[6]) & ~lsad_pkg::ATTR_WMASK)
         | (attr_regs[0] & ~lsad_pkg::SYSFW_WMASK)) == 8'h00)
        else $error("reserved attribute bit stored");

    COV_SHADOW_COPY: cover property (
        cpu_attr_seg & (cpu_field[1:0] == 2'b10) & ~cpu_write_i
        ##[1:8] cpu_attr_seg & cpu_write_i & (cpu_field[1:0] == 2'b10));
    COV_CODE_CACHE: cover property (cpu_valid_o & cpu_l1_cache_o & ~cpu_to_pci_o);
    COV_PCI_REFUSED: cover property (pci_attr_seg ##1 ~pci_claim_o);
    COV_BUS_WRITE: cover property (bus_write & attr_hit);
    COV_HOLE_ACCESS: cover property (pci_req_i & pci_in_hole);
endmodule

// *** src/lsad_pkg.sv ***
// constants shared by the legacy segment attribute decoder
package lsad_pkg;
    // register indices; byte address is index times four
    localparam logic [7:0] SYSFW_ATTR_IDX   = 8'h59;
    localparam logic [7:0] EXP_C0_C7_IDX    = 8'h5A;
    localparam logic [7:0] EXP_C8_CF_IDX    = 8'h5B;
    localparam logic [7:0] EXP_D0_D7_IDX    = 8'h5C;
    localparam logic [7:0] EXP_D8_DF_IDX    = 8'h5D;
    localparam logic [7:0] FW_EXT_E0_E7_IDX = 8'h5E;
    localparam logic [7:0] FW_EXT_E8_EF_IDX = 8'h5F;
    localparam logic [7:0] STATUS_IDX       = 8'h50;
    localparam logic [7:0] TOP_MEM_IDX      = 8'h51;
    localparam logic [7:0] HOLE_IDX         = 8'h52;
    localparam int         NUM_ATTR_REGS    = 7;
    localparam int         NUM_SEGS         = 13;
    localparam int         SYSFW_SEG        = 12;
    // field layout inside one nibble
    localparam int         NIBBLE_W         = 4;
    localparam int         RE_BIT           = 0;
    localparam int         WE_BIT           = 1;
    localparam int         CE_BIT           = 2;
    localparam logic [7:0] ATTR_WMASK       = 8'h77;
    localparam logic [7:0] SYSFW_WMASK      = 8'h70;
    localparam logic [7:0] ATTR_RESET       = 8'h00;
    // own control registers
    localparam int         HOLE_EN_BIT      = 0;
    localparam int         HOLE_START_LSB   = 8;
    localparam int         HOLE_END_LSB     = 16;
    localparam logic [31:0] HOLE_WMASK      = 32'h00FFFF01;
    localparam logic [31:0] HOLE_RESET      = 32'h00000000;
    localparam logic [7:0] TOP_MEM_RESET    = 8'h00;
    // address map below one megabyte
    localparam logic [19:0] VIDEO_BASE      = 20'hA0000;
    localparam logic [19:0] EXP_BASE        = 20'hC0000;
    localparam logic [3:0]  SYSFW_NIB       = 4'hF;
    localparam int          SEG_LSB         = 14;

    typedef enum logic [1:0] {
        LSAD_REG_LOW   = 2'b00,
        LSAD_REG_VIDEO = 2'b01,
        LSAD_REG_ATTR  = 2'b10,
        LSAD_REG_EXT   = 2'b11
    } lsad_region_t;
endpackage

// *** src/lsad_attr_if.sv ***
// per-segment attribute nibbles carried from the registers to the lookups
`timescale 1ns/1ps
interface lsad_attr_if;
    logic [3:0] seg_attr [lsad_pkg::NUM_SEGS];
    modport owner  (output seg_attr);
    modport reader (input  seg_attr);
endinterface

// *** src/lsad_seg_lookup.sv ***
// address to region class and segment attribute nibble
`timescale 1ns/1ps
module lsad_seg_lookup (
    input  wire logic [31:0]           addr_i,
    lsad_attr_if.reader                attr,
    output lsad_pkg::lsad_region_t     region_o,
    output logic [3:0]                 field_o
);
    always_comb begin
        region_o = lsad_pkg::LSAD_REG_EXT;
        field_o  = 4'h0;
        if (addr_i[31:20] != 12'h000) begin
            region_o = lsad_pkg::LSAD_REG_EXT;
        end else if (addr_i[19:0] < lsad_pkg::VIDEO_BASE) begin
            region_o = lsad_pkg::LSAD_REG_LOW;
        end else if (addr_i[19:0] < lsad_pkg::EXP_BASE) begin
            region_o = lsad_pkg::LSAD_REG_VIDEO;
        end else if (addr_i[19:16] == lsad_pkg::SYSFW_NIB) begin
            region_o = lsad_pkg::LSAD_REG_ATTR;
            field_o  = attr.seg_attr[lsad_pkg::SYSFW_SEG];
        end else begin
            // C0000..EFFFF: bits 17:14 give segments 0..11 directly
            region_o = lsad_pkg::LSAD_REG_ATTR;
            field_o  = attr.seg_attr[addr_i[lsad_pkg::SEG_LSB+:4]];
        end
    end
endmodule

// *** src/lsad_route_decode.sv ***
// cpu cycle routing and first-level cacheability from one attribute nibble
`timescale 1ns/1ps
module lsad_route_decode (
    input  lsad_pkg::lsad_region_t region_i,
    input  wire logic [3:0]        field_i,
    input  wire logic              write_i,
    input  wire logic              code_i,
    output logic                   to_mem_o,
    output logic                   to_pci_o,
    output logic                   l1_o
);
    logic re;
    logic we;
    logic ce;
    assign re = field_i[lsad_pkg::RE_BIT];
    assign we = field_i[lsad_pkg::WE_BIT];
    assign ce = field_i[lsad_pkg::CE_BIT];

    always_comb begin
        to_mem_o = 1'b0;
        to_pci_o = 1'b0;
        l1_o     = 1'b0;
        case (region_i)
            lsad_pkg::LSAD_REG_LOW: begin
                to_mem_o = 1'b1;
                l1_o     = 1'b1;
            end
            lsad_pkg::LSAD_REG_VIDEO: begin
                to_pci_o = 1'b1;
            end
            lsad_pkg::LSAD_REG_ATTR: begin
                // disabled, read-only write and write-only read all fall to pci
                to_mem_o = write_i ? we : re;
                to_pci_o = write_i ? ~we : ~re;
                // read-only areas cache code fetches only; ce ignored when re is low
                l1_o     = ~write_i & ce & re & (we | code_i);
            end
            default: begin
                to_mem_o = 1'b0;
            end
        endcase
    end
endmodule

// *** sim/lsad_far_side.sv ***
// far side model: cpu host cycles and pci master cycles
`timescale 1ns/1ps
module lsad_far_side (
    input  wire logic        clk_i,
    output logic             cpu_req_o,
    output logic      [31:0] cpu_addr_o,
    output logic             cpu_write_o,
    output logic             cpu_code_o,
    output logic             pci_req_o,
    output logic      [31:0] pci_addr_o,
    output logic             pci_write_o
);
    // ****************
    // cycle launchers
    // ****************
    initial begin
        {cpu_req_o, cpu_write_o, cpu_code_o, pci_req_o, pci_write_o} = 5'h00;
        cpu_addr_o = 32'h00000000;
        pci_addr_o = 32'h00000000;
    end
    // gap gives prompt and slow masters; released lines carry the inverse value
    task automatic cpu_cycle(input logic [31:0] a, input logic w, input logic c, input int gap);
        repeat (gap + 1) @(posedge clk_i);
        cpu_req_o   <= 1'b1;
        cpu_addr_o  <= a;
        cpu_write_o <= w;
        cpu_code_o  <= c & ~w;
        @(posedge clk_i);
        cpu_req_o   <= 1'b0;
        cpu_addr_o  <= ~a;
        cpu_write_o <= ~w;
        cpu_code_o  <= ~c;
    endtask
    task automatic pci_cycle(input logic [31:0] a, input logic w, input int gap);
        repeat (gap + 1) @(posedge clk_i);
        pci_req_o   <= 1'b1;
        pci_addr_o  <= a;
        pci_write_o <= w;
        @(posedge clk_i);
        pci_req_o   <= 1'b0;
        pci_addr_o  <= ~a;
        pci_write_o <= ~w;
    endtask
endmodule

// *** sim/tb_legacy_segment_attribute_decoder.sv ***
// self-checking bench: register bus, cpu routing and pci claim
`timescale 1ns/1ps
module tb_legacy_segment_attribute_decoder;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o, cpu_addr_i, pci_addr_i;
    logic        wb_ack_o, cpu_req_i, cpu_write_i, cpu_code_i, cpu_valid_o, cpu_to_mem_o;
    logic        cpu_to_pci_o, cpu_l1_cache_o, pci_req_i, pci_write_i, pci_valid_o, pci_claim_o;
    int          errors = 0;
    int          checks = 0;
    integer      seed   = 32'h5B7E;
    logic        prompt = 1'b0;   // launch the cpu cycle at the ack edge of a write
    logic [2:0]  cpu_last = 3'b000;
    logic [31:0] regs_m [256] = '{default: 32'h00000000};
    int          codes [$] = '{0, 2, 1, 5, 3, 7};   // write-only before read-only
    // no second-level cache here, so cache bits may change freely

    lsad_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_req_i, .cpu_addr_i, .cpu_write_i, .cpu_code_i,
        .cpu_valid_o, .cpu_to_mem_o, .cpu_to_pci_o, .cpu_l1_cache_o, .pci_req_i, .pci_addr_i,
        .pci_write_i, .pci_valid_o, .pci_claim_o);
    lsad_far_side far_u (.clk_i, .cpu_req_o(cpu_req_i), .cpu_addr_o(cpu_addr_i),
        .cpu_write_o(cpu_write_i), .cpu_code_o(cpu_code_i), .pci_req_o(pci_req_i),
        .pci_addr_o(pci_addr_i), .pci_write_o(pci_write_i));

    always #2.5 clk_i = ~clk_i;

    // ****************
    // reference model
    // ****************
    function automatic logic [31:0] wmask(logic [7:0] i);
        if (i == lsad_pkg::SYSFW_ATTR_IDX) return {24'h000000, lsad_pkg::SYSFW_WMASK};
        if (i >= lsad_pkg::EXP_C0_C7_IDX && i <= lsad_pkg::FW_EXT_E8_EF_IDX)
            return {24'h000000, lsad_pkg::ATTR_WMASK};
        if (i == lsad_pkg::TOP_MEM_IDX) return 32'h000000FF;
        if (i == lsad_pkg::HOLE_IDX) return lsad_pkg::HOLE_WMASK;
        return 32'h00000000;
    endfunction
    function automatic logic [3:0] nib(logic [19:0] a);
        int s;
        s = int'((a - 20'hC0000) >> 14);
        if (s >= 12) return regs_m[8'h59][7:4];
        return 4'(regs_m[8'h5A + s / 2] >> (4 * (s % 2)));
    endfunction
    // result order is {mem, pci, l1}; above 1 MB both routes stay low
    function automatic logic [2:0] cpu_exp(logic [31:0] a, logic w, logic c);
        logic [3:0] n;
        if (a[31:20] != 12'h000) return 3'b000;
        if (a[19:0] < 20'hA0000) return 3'b101;
        if (a[19:0] < 20'hC0000) return 3'b010;
        n = nib(a[19:0]);
        if (w) return {n[1], ~n[1], 1'b0};
        return {n[0], ~n[0], n[2] & n[0] & (n[1] | c)};
    endfunction
    function automatic logic pci_exp(logic [31:0] a, logic w);
        logic [3:0]  n;
        logic [31:0] h;
        h = regs_m[8'h52];
        if (h[0] && a[31:20] >= {4'h0, h[15:8]} && a[31:20] < {4'h0, h[23:16]}) return 1'b0;
        if (a[31:20] != 12'h000) return a[31:20] < {4'h0, regs_m[8'h51][7:0]};
        if (a[19:0] < 20'hA0000) return 1'b1;
        if (a[19:0] < 20'hC0000) return 1'b0;
        n = nib(a[19:0]);
        return w ? n[1] : n[0];
    endfunction

    // ****************
    // bus and checks
    // ****************
    task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb_cycle(logic we, logic [9:0] adr, logic [3:0] sel, logic [31:0] dat,
                            output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic reg_write(logic [9:0] adr, logic [3:0] sel, logic [31:0] dat);
        logic [31:0] rd;
        wb_cycle(1'b1, adr, sel, dat, rd);
        if (sel[0]) regs_m[adr[9:2]] = dat & wmask(adr[9:2]);
    endtask
    task automatic reg_check(logic [7:0] i);
        logic [31:0] rd;
        wb_cycle(1'b0, {i, 2'b00}, 4'hF, 32'h00000000, rd);
        compare("register", regs_m[i], rd);
    endtask
    task automatic cpu_check(logic [31:0] a, logic w, logic c);
        logic [2:0] e;
        e = cpu_exp(a, w, c & ~w);
        cpu_last = e;
        far_u.cpu_cycle(a, w, c, prompt ? -1 : $random(seed) & 1);
        #1;
        compare("cpu route", {28'h0000000, 1'b1, e},
                {28'h0000000, cpu_valid_o, cpu_to_mem_o, cpu_to_pci_o, cpu_l1_cache_o});
    endtask
    task automatic pci_check(logic [31:0] a, logic w);
        logic e;
        e = pci_exp(a, w);
        far_u.pci_cycle(a, w, $random(seed) & 1);
        #1;
        compare("pci claim", {30'h00000000, 1'b1, e},
                {30'h00000000, pci_valid_o, pci_claim_o});
    endtask
    task automatic probe(logic [31:0] a);
        cpu_check(a, 1'b0, 1'b0);
        if (a >= 32'h000A0000) cpu_check(a, 1'b1, 1'b0);
        cpu_check(a, 1'b0, 1'b1);
        pci_check(a, 1'b0);
        pci_check(a, 1'b1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        test_done();
    end

    initial begin
        int r, k, s;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 8'h50; k < 8'h60; k++) reg_check(k[7:0]);
        reg_check(8'hFF);
        $display("test reset values done");
        for (r = 0; r < 12; r++) begin
            for (k = 0; k < 7; k++)
                reg_write({k[7:0] + 8'h59, 2'b00}, 4'hF, ($random(seed) & 32'hFFFFFF88)
                          | (codes[(r + 2 * k + 1) % 6] << 4) | codes[(r + k) % 6]);
            for (k = 8'h59; k < 8'h60; k++) reg_check(k[7:0]);
            for (s = 0; s < 13; s++)
                probe(32'h000C0000 + (s << 14)
                      + ($random(seed) & (s == 12 ? 32'h0000FFFF : 32'h00003FFF)));
            probe({$random(seed)} % 32'h000A0000);
            probe(32'h000A0000 + ({$random(seed)} % 32'h00020000));
        end
        $display("test attribute sweep done");
        reg_write(10'h144, 4'hF, 32'h00000002);
        probe(32'h00100000);
        probe(32'h00200000);
        reg_write(10'h148, 4'hF, 32'hFF020101);
        reg_check(8'h52);
        probe(32'h00180000);
        reg_write(10'h148, 4'hF, 32'h00010001);
        probe(32'h00012344);
        reg_write(10'h148, 4'hF, 32'h00000000);
        $display("test hole done");
        reg_write(10'h168, 4'hE, 32'h00000077);
        reg_write(10'h3FC, 4'hF, 32'hFFFFFFFF);
        reg_check(8'h5A);
        reg_write(10'h168, 4'hF, 32'h00000070);
        prompt = 1'b1;
        cpu_check(32'h000C0100, 1'b0, 1'b0);
        prompt = 1'b0;
        reg_check(8'hFF);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        regs_m = '{default: 32'h00000000};
        for (k = 8'h50; k < 8'h60; k++) reg_check(k[7:0]);
        probe(32'h000E4000);
        regs_m[8'h50] = {29'h00000000, cpu_last[0], cpu_last[1], cpu_last[2]};
        reg_check(8'h50);
        $display("test refusals and second reset done");
        test_done();
    end
endmodule
